// *** design/sdw_display_port.sv ***
// Notes on behaviour
// - command/data line low marks command byte, high marks data byte.
// - one write bit captured per rising serial clock edge while selected.
// - eight bits form one byte; byte completes on eighth edge.
// - read data returns on shared serial read line.
// - touch event drives touch interrupt line low while touch reset line is high.
// - pixels are 16-bit rgb565 words.
// - pixel address steps by rows and columns per scan mode.
// - display held in on-chip frame memory of full-frame capacity.
`timescale 1ns/10ps
module sdw_display_port (
	// system
	input wire logic clk_i,
	input wire logic rst_n_i,
	// serial link
	input wire logic sclk_i,
	input wire logic controller_select_n_i,
	input wire logic cmd_data_pin_i,
	input wire logic sdi_i,
	input wire logic card_select_n_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// touch sideband
	input wire logic touch_event_i,
	input wire logic touch_reset_n_i,
	output logic touch_irq_n_o,
	// status
	output logic [7:0] scan_mode_o,
	output logic pix_wr_o,
	output logic [sdw_pkg::ADDR_W-1:0] pix_addr_o,
	output logic [sdw_pkg::PIX_BITS-1:0] pix_o
);
	import sdw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link domain: shift in bytes
	logic link_rst_n;
	logic [6:0] shift_in;
	logic [2:0] bit_cnt;
	logic [7:0] byte_hold;
	logic dc_hold;
	logic byte_tog;

	// deselect clears the receiver so stray clocks are ignored
	assign link_rst_n = rst_n_i & ~controller_select_n_i;

	always_ff @(posedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_in <= 7'h00;
			bit_cnt <= 3'h0;
		end else begin
			shift_in <= {shift_in[5:0], sdi_i};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// holding register and toggle survive deselect for the crossing
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_hold <= 8'h00;
			dc_hold <= 1'b0;
			byte_tog <= 1'b0;
		end else if (!controller_select_n_i && bit_cnt == 3'h7) begin
			byte_hold <= {shift_in, sdi_i};
			dc_hold <= cmd_data_pin_i;
			byte_tog <= ~byte_tog;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: read data out on falling edge
	logic rd_mode;
	logic [15:0] rd_word;
	logic rd_sync1;
	logic rd_sync2;
	logic [15:0] rd_shift;
	logic rd_armed;

	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_sync1 <= 1'b0;
			rd_sync2 <= 1'b0;
		end else begin
			rd_sync1 <= rd_mode;
			rd_sync2 <= rd_sync1;
		end
	end

	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rd_shift <= 16'h0000;
			rd_armed <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_oe_o <= rd_sync2 & card_select_n_i;
			if (!rd_sync2) begin
				rd_shift <= rd_word;
				rd_armed <= 1'b0;
				sdo_o <= 1'b0;
			end else if (rd_armed || bit_cnt == 3'h0) begin
				// start on a byte boundary so read words line up with bytes
				rd_armed <= 1'b1;
				sdo_o <= rd_shift[15];
				rd_shift <= {rd_shift[14:0], rd_shift[15]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system domain: byte arrival
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic byte_stb;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= byte_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	assign byte_stb = tog_s2 ^ tog_s3;

	////////////////////////////////////////////////////////////////////////
	// system domain: command decode
	sdw_state_t state;
	sdw_state_t next_state;
	logic [1:0] param_idx;
	logic [8:0] col_lo, col_hi, row_lo, row_hi, col, row;
	logic [7:0] scan_mode;
	logic pix_half;
	logic [7:0] pix_msb;
	logic is_cmd;

	assign is_cmd = byte_stb & ~dc_hold;

	always_comb begin
		next_state = state;
		if (is_cmd) begin
			case (byte_hold)
				CMD_COL_SET: next_state = SDW_COL;
				CMD_ROW_SET: next_state = SDW_ROW;
				CMD_MEM_WRITE: next_state = SDW_WRITE;
				CMD_MEM_READ: next_state = SDW_READ;
				CMD_SCAN_MODE: next_state = SDW_SCAN;
				default: next_state = SDW_IDLE;
			endcase
		end else if (byte_stb) begin
			case (state)
				SDW_SCAN: next_state = SDW_IDLE;
				SDW_COL, SDW_ROW: begin
					if (param_idx == LAST_ADDR_PARAM) begin
						next_state = SDW_IDLE;
					end
				end
				default: next_state = state;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= SDW_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			param_idx <= 2'h0;
		end else if (is_cmd) begin
			param_idx <= 2'h0;
		end else if (byte_stb) begin
			param_idx <= param_idx + 2'h1;
		end
	end

	// address window parameters, high byte first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			col_lo <= 9'h000;
			row_lo <= 9'h000;
			col_hi <= 9'(COLS - 1);
			row_hi <= 9'(ROWS - 1);
		end else if (byte_stb && dc_hold) begin
			case ({state, param_idx})
				{SDW_COL, 2'h0}: col_lo[8] <= byte_hold[0];
				{SDW_COL, 2'h1}: col_lo[7:0] <= byte_hold;
				{SDW_COL, 2'h2}: col_hi[8] <= byte_hold[0];
				{SDW_COL, 2'h3}: col_hi[7:0] <= byte_hold;
				{SDW_ROW, 2'h0}: row_lo[8] <= byte_hold[0];
				{SDW_ROW, 2'h1}: row_lo[7:0] <= byte_hold;
				{SDW_ROW, 2'h2}: row_hi[8] <= byte_hold[0];
				{SDW_ROW, 2'h3}: row_hi[7:0] <= byte_hold;
				default: col_lo <= col_lo;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_mode <= SCAN_RESET;
		end else if (byte_stb && dc_hold && state == SDW_SCAN) begin
			scan_mode <= byte_hold;
		end
	end

	assign scan_mode_o = scan_mode;

	////////////////////////////////////////////////////////////////////////
	// pixel assembly, address stepping and frame memory
	logic [15:0] frame_mem [0:FRAME_PIXELS-1];
	logic pix_done;
	logic [15:0] pix_word;
	logic [ADDR_W-1:0] cur_addr;
	logic col_end, row_end;
	logic [8:0] col_start, row_start;
	logic [8:0] next_col, next_row;

	assign pix_done = byte_stb & dc_hold & pix_half & (state == SDW_WRITE);
	assign pix_word = {pix_msb, byte_hold};
	assign cur_addr = ADDR_W'(row) * ADDR_W'(COLS) + ADDR_W'(col);
	assign col_start = scan_mode[SCAN_COL_DEC] ? col_hi : col_lo;
	assign row_start = scan_mode[SCAN_ROW_DEC] ? row_hi : row_lo;
	assign col_end = scan_mode[SCAN_COL_DEC] ? (col == col_lo) : (col == col_hi);
	assign row_end = scan_mode[SCAN_ROW_DEC] ? (row == row_lo) : (row == row_hi);

	always_comb begin
		next_col = col;
		next_row = row;
		if (scan_mode[SCAN_SWAP]) begin
			next_row = row_end ? row_start :
				(scan_mode[SCAN_ROW_DEC] ? row - 9'h1 : row + 9'h1);
			if (row_end) begin
				next_col = col_end ? col_start :
					(scan_mode[SCAN_COL_DEC] ? col - 9'h1 : col + 9'h1);
			end
		end else begin
			next_col = col_end ? col_start :
				(scan_mode[SCAN_COL_DEC] ? col - 9'h1 : col + 9'h1);
			if (col_end) begin
				next_row = row_end ? row_start :
					(scan_mode[SCAN_ROW_DEC] ? row - 9'h1 : row + 9'h1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			col <= 9'h000;
			row <= 9'h000;
		end else if (is_cmd && (byte_hold == CMD_MEM_WRITE ||
				byte_hold == CMD_MEM_READ)) begin
			col <= col_start;
			row <= row_start;
		end else if (pix_done) begin
			col <= next_col;
			row <= next_row;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pix_half <= 1'b0;
			pix_msb <= 8'h00;
		end else if (is_cmd) begin
			pix_half <= 1'b0;
		end else if (byte_stb && dc_hold && state == SDW_WRITE) begin
			pix_half <= ~pix_half;
			pix_msb <= byte_hold;
		end
	end

	always_ff @(posedge clk_i) begin
		if (pix_done) begin
			frame_mem[cur_addr] <= pix_word;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pix_wr_o <= 1'b0;
			pix_addr_o <= '0;
			pix_o <= 16'h0000;
		end else begin
			pix_wr_o <= pix_done;
			if (pix_done) begin
				pix_addr_o <= cur_addr;
				pix_o <= pix_word;
			end
		end
	end

	// read word is loaded before read mode rises, so it is stable when sampled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_mode <= 1'b0;
			rd_word <= 16'h0000;
		end else if (is_cmd) begin
			rd_mode <= 1'b0;
			if (byte_hold == CMD_MEM_READ) begin
				rd_word <= frame_mem[ADDR_W'(row_start) * ADDR_W'(COLS) +
					ADDR_W'(col_start)];
			end
		end else if (state == SDW_READ) begin
			rd_mode <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// touch sideband
	logic te_s1, te_s2, tr_s1, tr_s2;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			te_s1 <= 1'b0;
			te_s2 <= 1'b0;
			tr_s1 <= 1'b0;
			tr_s2 <= 1'b0;
			touch_irq_n_o <= 1'b1;
		end else begin
			te_s1 <= touch_event_i;
			te_s2 <= te_s1;
			tr_s1 <= touch_reset_n_i;
			tr_s2 <= tr_s1;
			touch_irq_n_o <= ~(te_s2 & tr_s2);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_sel_gate;
		@(posedge sclk_i) disable iff (!rst_n_i)
		controller_select_n_i |-> bit_cnt == 3'h0;
	endproperty
	a_sel_gate: assert property (p_sel_gate) else $error("counting deselected");

	property p_bit_step;
		@(posedge sclk_i) disable iff (!link_rst_n)
		$past(!controller_select_n_i) |-> bit_cnt == $past(bit_cnt) + 3'h1;
	endproperty
	a_bit_step: assert property (p_bit_step) else $error("bit count slip");

	property p_byte_done;
		@(posedge sclk_i) disable iff (!rst_n_i)
		(!controller_select_n_i && bit_cnt == 3'h7) |=>
			byte_tog != $past(byte_tog) && byte_hold[0] == $past(sdi_i);
	endproperty
	a_byte_done: assert property (p_byte_done) else $error("byte not closed");

	property p_cmd_class;
		@(posedge clk_i) disable iff (!rst_n_i)
		(byte_stb && dc_hold && state == SDW_IDLE) |=> state == SDW_IDLE;
	endproperty
	a_cmd_class: assert property (p_cmd_class) else $error("data as command");

	property p_pix_out;
		@(posedge clk_i) disable iff (!rst_n_i)
		pix_done |=> pix_wr_o && pix_o == $past(pix_word)
			&& pix_addr_o == $past(cur_addr);
	endproperty
	a_pix_out: assert property (p_pix_out) else $error("pixel lost");

	property p_step;
		@(posedge clk_i) disable iff (!rst_n_i)
		(pix_done && !scan_mode[SCAN_SWAP] && !scan_mode[SCAN_COL_DEC]
			&& !col_end) |=> col == $past(col) + 9'h1 && row == $past(row);
	endproperty
	a_step: assert property (p_step) else $error("bad address step");

	property p_mem;
		@(posedge clk_i) disable iff (!rst_n_i)
		pix_done |=> frame_mem[$past(cur_addr)] == $past(pix_word);
	endproperty
	a_mem: assert property (p_mem) else $error("frame memory miss");

	property p_irq;
		@(posedge clk_i) disable iff (!rst_n_i)
		(touch_event_i && touch_reset_n_i)[*4] |-> !touch_irq_n_o;
	endproperty
	a_irq: assert property (p_irq) else $error("touch not flagged");

	property p_sdo_idle;
		@(negedge sclk_i) disable iff (!link_rst_n)
		!rd_sync2 |=> !sdo_oe_o;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("read line driven");

	c_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) pix_done);
	c_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		state == SDW_READ && rd_mode);
	c_scan: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		pix_done && scan_mode[SCAN_SWAP]);
	c_touch: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(touch_irq_n_o));
endmodule : sdw_display_port

// *** design/sdw_pkg.sv ***
package sdw_pkg;
	// panel geometry and frame memory
	localparam int unsigned COLS = 240;
	localparam int unsigned ROWS = 320;
	localparam int unsigned FRAME_BYTES = 172800;
	localparam int unsigned FRAME_PIXELS = COLS * ROWS;
	localparam int unsigned ADDR_W = 17;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned PIX_BITS = 16;
	// rgb565 field positions
	localparam int unsigned RED_LSB = 11;
	localparam int unsigned GREEN_LSB = 5;
	localparam int unsigned BLUE_LSB = 0;
	// command codes
	localparam logic [7:0] CMD_COL_SET = 8'h2A;
	localparam logic [7:0] CMD_ROW_SET = 8'h2B;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
	localparam logic [7:0] CMD_MEM_READ = 8'h2E;
	localparam logic [7:0] CMD_SCAN_MODE = 8'h36;
	// scan mode bits
	localparam int unsigned SCAN_ROW_DEC = 7;
	localparam int unsigned SCAN_COL_DEC = 6;
	localparam int unsigned SCAN_SWAP = 5;
	localparam logic [7:0] SCAN_RESET = 8'h00;
	localparam logic [1:0] LAST_ADDR_PARAM = 2'h3;
	typedef enum logic [2:0] {
		SDW_IDLE = 3'b000,
		SDW_COL = 3'b001,
		SDW_ROW = 3'b010,
		SDW_WRITE = 3'b011,
		SDW_READ = 3'b100,
		SDW_SCAN = 3'b101
	} sdw_state_t;
endpackage : sdw_pkg

// *** dv/sdw_host.sv ***
`timescale 1ns/10ps
module sdw_host (
	// serial link toward the display
	output logic sclk_o,
	output logic cs_n_o,
	output logic dc_o,
	output logic sdi_o,
	output logic card_n_o,
	// read data from the display
	input wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		dc_o = 1'b0;
		sdi_o = 1'b0;
		card_n_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// select or release the display; a released data line shows the inverse
	task automatic sel(input logic on);
		#5;
		cs_n_o = ~on;
		if (!on) begin
			sdi_o = ~sdi_o;
		end
		#27;
	endtask : sel
	// one byte, clock idles low, data moves on the falling edge
	task automatic xfer(input logic dc, input logic [7:0] b);
		int i;
		dc_o = dc;
		for (i = 7; i >= 0; i--) begin
			sdi_o = b[i];
			#32 sclk_o = 1'b1;
			#32 sclk_o = 1'b0;
		end
	endtask : xfer
	task automatic rd(output logic [7:0] b);
		int i;
		dc_o = 1'b1;
		for (i = 7; i >= 0; i--) begin
			#32 sclk_o = 1'b1;
			b[i] = sdo_i;
			#32 sclk_o = 1'b0;
		end
	endtask : rd
endmodule : sdw_host

// *** dv/serial_display_write_port_bench.sv ***
`timescale 1ns/10ps
module serial_display_write_port_bench;
	import sdw_pkg::*;
	logic clk_i, rst_n_i, touch_event_i, touch_reset_n_i;
	logic sclk, cs_n, dc, sdi, card_n, sdo, sdo_oe, irq_n, pix_wr;
	logic [7:0] scan_mode, rb0, rb1;
	logic [7:0] modes [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
	logic [ADDR_W-1:0] pix_addr;
	logic [PIX_BITS-1:0] pix;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	sdw_display_port i_sdw_display_port (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sclk_i(sclk), .controller_select_n_i(cs_n), .cmd_data_pin_i(dc),
		.sdi_i(sdi), .card_select_n_i(card_n), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .touch_event_i(touch_event_i),
		.touch_reset_n_i(touch_reset_n_i), .touch_irq_n_o(irq_n),
		.scan_mode_o(scan_mode), .pix_wr_o(pix_wr), .pix_addr_o(pix_addr),
		.pix_o(pix));
	sdw_host i_sdw_host (.sclk_o(sclk), .cs_n_o(cs_n), .dc_o(dc),
		.sdi_o(sdi), .card_n_o(card_n), .sdo_i(sdo));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// command followed by a start and an end value, high byte first
	task automatic cmd4(input logic [7:0] c, input logic [15:0] a,
		input logic [15:0] b);
		i_sdw_host.xfer(1'b0, c);
		i_sdw_host.xfer(1'b1, a[15:8]);
		i_sdw_host.xfer(1'b1, a[7:0]);
		i_sdw_host.xfer(1'b1, b[15:8]);
		i_sdw_host.xfer(1'b1, b[7:0]);
	endtask : cmd4
	// one pixel, then its single write pulse at the frame port
	task automatic pixel(input logic [15:0] v, input logic [16:0] addr);
		int n;
		n = 0;
		i_sdw_host.xfer(1'b1, v[15:8]);
		// watch during the low byte: the pulse may come before it returns
		fork
			i_sdw_host.xfer(1'b1, v[7:0]);
			begin
				while (pix_wr !== 1'b1 && n < 80) begin
					@(negedge clk_i);
					n++;
				end
				check(n < 80, 1'b1);
				check(pix_addr, addr);
				check(pix, v);
				@(negedge clk_i);
				check(pix_wr, 1'b0);
			end
		join
	endtask : pixel
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		touch_event_i = 1'b0;
		touch_reset_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
		check({sdo_oe, irq_n, pix_wr, scan_mode, pix_addr, pix},
			{3'b010, 8'h00, 17'h0, 16'h0});
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		i_sdw_host.sel(1'b1);
		cmd4(CMD_COL_SET, 16'd238, 16'd239);
		cmd4(CMD_ROW_SET, 16'd258, 16'd259);
		i_sdw_host.xfer(1'b0, CMD_MEM_WRITE);
		pixel(16'hF800, 17'd62158);
		pixel(16'h07E0, 17'd62159);
		pixel(16'h001F, 17'd62398);
		pixel(16'hFFFF, 17'd62399);
		pixel(16'h1234, 17'd62158);
		foreach (modes[k]) begin
			i_sdw_host.xfer(1'b0, CMD_SCAN_MODE);
			i_sdw_host.xfer(1'b1, modes[k]);
			repeat (10) @(negedge clk_i);
			check(scan_mode, modes[k]);
		end
		// rows step first, then both directions reversed
		i_sdw_host.xfer(1'b0, CMD_SCAN_MODE);
		i_sdw_host.xfer(1'b1, 8'h20);
		i_sdw_host.xfer(1'b0, CMD_MEM_WRITE);
		pixel(16'hA5A5, 17'd62158);
		pixel(16'h5A5A, 17'd62398);
		pixel(16'h0F0F, 17'd62159);
		pixel(16'hF0F0, 17'd62399);
		i_sdw_host.xfer(1'b0, CMD_SCAN_MODE);
		i_sdw_host.xfer(1'b1, 8'hC0);
		i_sdw_host.xfer(1'b0, CMD_MEM_WRITE);
		pixel(16'h8001, 17'd62399);
		pixel(16'h4002, 17'd62398);
		pixel(16'h2004, 17'd62159);
		pixel(16'h1234, 17'd62158);
		i_sdw_host.xfer(1'b0, CMD_SCAN_MODE);
		i_sdw_host.xfer(1'b1, 8'h00);
		// scan command sent as data must not act
		i_sdw_host.xfer(1'b1, CMD_SCAN_MODE);
		i_sdw_host.xfer(1'b1, 8'h55);
		repeat (10) @(negedge clk_i);
		check(scan_mode, 8'h00);
		// traffic while deselected must be ignored
		i_sdw_host.sel(1'b0);
		i_sdw_host.xfer(1'b0, CMD_SCAN_MODE);
		i_sdw_host.xfer(1'b1, 8'hFF);
		i_sdw_host.sel(1'b1);
		repeat (10) @(negedge clk_i);
		check(scan_mode, 8'h00);
		i_sdw_host.xfer(1'b0, CMD_MEM_READ);
		i_sdw_host.xfer(1'b1, 8'h00);
		i_sdw_host.rd(rb0);
		i_sdw_host.rd(rb1);
		check({rb0, rb1}, 16'h1234);
		#5 check(sdo_oe, 1'b1);
		i_sdw_host.sel(1'b0);
		#20 check(sdo_oe, 1'b0);
		@(negedge clk_i);
		touch_event_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check(irq_n, 1'b1);
		repeat (2) @(negedge clk_i);
		check(irq_n, 1'b0);
		touch_reset_n_i = 1'b0;
		repeat (4) @(negedge clk_i);
		check(irq_n, 1'b1);
		final_report();
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			final_report();
		end
	end
endmodule : serial_display_write_port_bench
